// file: core/ufb_config.sv
// configuration, baud prescaler, parity, address filter and infrared stage of a serial transceiver
// assumes shift engines outside use cfg, baud_tick and the parity and accept pulses; apb master outside
//
// Summary of operation
// RULE1: receiver mode 0x3 selects lin constrained auto-baud from break and sync.
// RULE2: address filter set discards frames without address bit; transmitter unaffected.
// RULE3: mode 0 async, 1 sync, 2 infrared, 3 master spi with spi field layout.
// RULE4: parity field 0 off, 1 reserved, 2 even, 3 odd.
// RULE5: with parity on, transmitter appends parity; receiver flags mismatches.
// RULE6: stop bit select gives one or two transmit stop bits; receiver ignores it.
// RULE7: character size 5 to 8 bits, 4-5 reserved, 6-7 nine bits low/high first.
// RULE8: spi bit order 0 msb first, 1 lsb first, both directions.
// RULE9: spi clock phase picks leading or trailing sampling edge.
// RULE10: baud divisor 16 bits, low byte at offset, high byte one above.
// RULE11: any baud write reloads the prescaler at once.
// RULE12: debug run 0 halts and ignores events while cpu halted; 1 keeps running.
// RULE13: event input enable feeds infrared receiver from event, cutting the receive pin.
// RULE14: pulse length only acts in infrared mode; zero gives 3/16 bit pulses.
// RULE15: pulse length 1 to 254 gives that many clock periods from baud edge.
// RULE16: pulse length 255 disables coding; signals pass unaltered.
// RULE17: software programs transmit pulse length before enabling the transmitter.
// RULE18: lin sync valid only if bit pairs are 16 +-3 samples and char is 0x55.
// RULE19: receive pulse length zero disables filter; x needs x+1 equal samples.
// RULE20: software programs receive pulse length before enabling the receiver.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns

module ufb_config
  import ufb_pkg::*;
(
  // clock, reset, enable
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // debug
  input  wire logic          cpu_halted,
  // engine side
  output ufb_cfg_s           cfg,
  output logic               baud_tick,
  output logic               engine_run,
  input  wire logic [8:0]    tx_data,
  output logic               tx_parity_bit,
  input  ufb_rx_frame_s      rx_frame,
  output logic               rx_accept,
  input  ufb_sync_s          sync_meas,
  output logic               sync_ok,
  output logic               sync_fail,
  // infrared stage
  input  wire logic          rxd_pin,
  input  wire logic          ir_event_in,
  input  wire logic          txd_raw,
  output logic               txd_pin,
  output logic               rx_to_engine
);

  typedef enum logic {AP_IDLE = 1'b0, AP_RESP = 1'b1} ufb_apb_e;

  ufb_apb_e    apb_state;
  logic [7:0]  frame_reg;
  logic [7:0]  rxtx_reg;
  logic [15:0] baud_divisor;
  logic        run_in_debug_halt;
  logic        ir_event_input_enable;
  logic [7:0]  tx_pulse_length;
  logic [6:0]  rx_pulse_length;
  logic        parity_error_flag;
  logic        sync_fail_flag;
  logic        sync_ok_flag;
  logic [15:0] baud_cnt;
  logic [15:0] pulse_cnt;
  logic [7:0]  filt_cnt;
  logic [31:0] next_prdata;
  logic [5:0]  idx;
  logic        wr;
  logic        run;
  logic        adv;
  logic        ir_mode;
  logic        ir_coding;
  logic        rx_src;
  logic [17:0] frac_len;
  logic [15:0] pulse_len;
  logic        rx_par_calc;
  logic        rx_par_err;
  logic        sync_good;
  logic [7:0]  status_rd;

  // parity of the data bits that the character size actually carries
  function automatic logic data_parity(input logic [8:0] d, input logic [2:0] sz);
    logic [8:0] m;
    m = 9'h1ff;
    case (sz)
      CS_5:    m = 9'h01f;
      CS_6:    m = 9'h03f;
      CS_7:    m = 9'h07f;
      CS_8:    m = 9'h0ff;
      default: m = 9'h1ff;
    endcase
    return ^(d & m);
  endfunction : data_parity

  // decode of the current access
  assign idx     = paddr[7:2];
  assign wr      = psel && penable && pwrite && pready;
  assign run     = run_in_debug_halt || !cpu_halted;      // see RULE12
  assign adv     = ce && run;
  assign ir_mode = (cfg.comm_mode_select == CM_IR);
  assign ir_coding = ir_mode && (tx_pulse_length != TX_PULSE_LENGTH_BYPASS);  // see RULE14 see RULE16

  // configuration view; the spi layout reuses the frame register bits
  assign cfg.comm_mode_select         = ufb_comm_mode_select_e'(frame_reg[7:6]);            // see RULE3
  assign cfg.parity_select            = ufb_parity_e'(frame_reg[5:4]);           // see RULE4
  assign cfg.stop_bit_select          = frame_reg[3];                            // see RULE6
  assign cfg.char_size                = ufb_csize_e'(frame_reg[2:0]);            // see RULE7
  assign cfg.spi_bit_order            = frame_reg[2];                            // see RULE8
  assign cfg.spi_clock_phase          = frame_reg[1];                            // see RULE9
  assign cfg.rx_mode                  = ufb_rxmode_e'(rxtx_reg[2:1]);
  assign cfg.lin_constrained_autobaud = (rxtx_reg[2:1] == RXM_LIN);              // see RULE1
  assign cfg.multiproc_address_filter = rxtx_reg[0];
  assign cfg.receiver_enable_bit      = rxtx_reg[7];
  assign cfg.transmitter_enable_bit   = rxtx_reg[6];

  // status word: sticky flags plus live run state
  always_comb
  begin
    status_rd               = 8'h00;
    status_rd[ST_PARITY_ERROR_FLAG]      = parity_error_flag;
    status_rd[ST_SYNC_FAIL] = sync_fail_flag;
    status_rd[ST_SYNC_OK]   = sync_ok_flag;
    status_rd[ST_RUN]       = engine_run;
  end

  // read mux; unmapped words read zero and raise pslverr
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (idx)
      REG_STATUS: next_prdata[7:0] = status_rd;
      REG_RXTX:   next_prdata[7:0] = rxtx_reg;
      REG_FRAME:  next_prdata[7:0] = (frame_reg[7:6] == CM_MASTER_SPI_MODE) ? (frame_reg & FRAME_SPI_MASK) : frame_reg;
      REG_BAUDL:  next_prdata[7:0] = baud_divisor[7:0];
      REG_BAUDH:  next_prdata[7:0] = baud_divisor[15:8];
      REG_DEBUG:  next_prdata[0]   = run_in_debug_halt;
      REG_EVIN:   next_prdata[0]   = ir_event_input_enable;
      REG_TX_PULSE_LENGTH:   next_prdata[7:0] = tx_pulse_length;
      REG_RX_PULSE_LENGTH:   next_prdata[6:0] = rx_pulse_length;
      default:    next_prdata = 32'h0000_0000;
    endcase
  end

  // apb handshake: one wait state, answer registered in the access phase
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      apb_state <= AP_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      case (apb_state)
        AP_IDLE:
        begin
          if (psel && penable)
          begin
            apb_state <= AP_RESP;
            pready    <= 1'b1;
            prdata    <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr   <= !(idx inside {REG_STATUS, REG_RXTX, REG_FRAME, REG_BAUDL, REG_BAUDH,
                                       REG_DEBUG, REG_EVIN, REG_TX_PULSE_LENGTH, REG_RX_PULSE_LENGTH});
          end
        end
        AP_RESP:
        begin
          apb_state <= AP_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
        default:
        begin
          apb_state <= AP_IDLE;
          pready    <= 1'b0;
        end
      endcase
    end
  end

  // software-written configuration; takes effect at the completing edge only
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame_reg             <= FRAME_RESET;
      rxtx_reg              <= RXTX_RESET;
      baud_divisor          <= BAUD_RESET;
      run_in_debug_halt     <= 1'b0;
      ir_event_input_enable <= 1'b0;
      tx_pulse_length       <= BYTE_RESET;
      rx_pulse_length       <= 7'h00;
    end
    else if (ce && wr)
    begin
      case (idx)
        REG_RXTX:  rxtx_reg <= pwdata[7:0] & RXTX_MASK;
        REG_FRAME: frame_reg <= pwdata[7:0];                  // see RULE3
        REG_BAUDL: baud_divisor[7:0] <= pwdata[7:0];          // see RULE10
        REG_BAUDH: baud_divisor[15:8] <= pwdata[7:0];         // see RULE10
        REG_DEBUG: run_in_debug_halt <= pwdata[0];
        REG_EVIN:  ir_event_input_enable <= pwdata[0];
        REG_TX_PULSE_LENGTH:  tx_pulse_length <= pwdata[7:0];            // see RULE17
        REG_RX_PULSE_LENGTH:  rx_pulse_length <= pwdata[6:0] & RX_PULSE_LENGTH_MASK[6:0];  // see RULE20
        default:   rxtx_reg <= rxtx_reg;
      endcase
    end
  end

  // live run indication for engines and status
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      engine_run <= 1'b0;
    else if (ce)
      engine_run <= run;                                       // see RULE12
  end

  // baud prescaler; a baud write restarts the count, corrupting a frame in flight by design
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      baud_cnt  <= 16'h0000;
      baud_tick <= 1'b0;
    end
    else if (ce && wr && (idx == REG_BAUDL || idx == REG_BAUDH))
    begin
      baud_cnt  <= 16'h0000;                                   // see RULE11
      baud_tick <= 1'b0;
    end
    else if (adv)
    begin
      baud_tick <= (baud_cnt >= baud_divisor);
      baud_cnt  <= (baud_cnt >= baud_divisor) ? 16'h0000 : baud_cnt + 16'h0001;
    end
    else if (ce)
      baud_tick <= 1'b0;                                       // halted: no bit edges
  end

  // transmit parity for the engine; reserved setting behaves as no parity
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tx_parity_bit <= 1'b0;
    else if (adv)
      tx_parity_bit <= cfg.parity_select[1]
                       && (data_parity(tx_data, frame_reg[2:0]) ^ (cfg.parity_select == PAR_ODD));  // see RULE5
  end

  // receive check: address filter first, then parity of kept frames
  assign rx_par_calc = data_parity(rx_frame.data, frame_reg[2:0]) ^ (cfg.parity_select == PAR_ODD);
  assign rx_par_err  = rx_frame.valid && !(cfg.multiproc_address_filter && !rx_frame.addr_bit)
                       && cfg.parity_select[1] && (rx_par_calc != rx_frame.parity_bit);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rx_accept <= 1'b0;
    else if (ce)
      rx_accept <= adv && rx_frame.valid && !(cfg.multiproc_address_filter && !rx_frame.addr_bit);  // see RULE2
  end

  // lin sync: constrained bit-pair lengths and the fixed sync character
  assign sync_good = (sync_meas.char_val == SYNC_CHAR) && (sync_meas.pair_min >= SYNC_PAIR_LO)
                     && (sync_meas.pair_max <= SYNC_PAIR_HI);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_ok   <= 1'b0;
      sync_fail <= 1'b0;
    end
    else if (ce)
    begin
      sync_ok   <= adv && sync_meas.done && cfg.lin_constrained_autobaud && sync_good;   // see RULE18
      sync_fail <= adv && sync_meas.done && cfg.lin_constrained_autobaud && !sync_good;  // see RULE18
    end
  end

  // sticky status flags: write one clears, a new event in the same cycle wins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      parity_error_flag <= 1'b0;
      sync_fail_flag    <= 1'b0;
      sync_ok_flag      <= 1'b0;
    end
    else if (ce)
    begin
      parity_error_flag <= (adv && rx_par_err) ||
                           (parity_error_flag && !(wr && idx == REG_STATUS && pwdata[ST_PARITY_ERROR_FLAG]));  // see RULE5
      sync_fail_flag    <= sync_fail || (sync_fail_flag && !(wr && idx == REG_STATUS && pwdata[ST_SYNC_FAIL]));
      sync_ok_flag      <= sync_ok || (sync_ok_flag && !(wr && idx == REG_STATUS && pwdata[ST_SYNC_OK]));
    end
  end

  // infrared transmit pulse width; the fraction never drops below one clock
  assign frac_len  = ({2'b00, baud_divisor} * {16'h0000, PULSE_NUM}) >> PULSE_SHIFT;
  assign pulse_len = (tx_pulse_length == TX_PULSE_LENGTH_FRACTION)
                     ? ((frac_len[15:0] == 16'h0000) ? 16'h0001 : frac_len[15:0])   // see RULE14
                     : {8'h00, tx_pulse_length};                                     // see RULE15

  // a zero bit gives one low pulse starting at the bit edge; idle line stays high
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pulse_cnt <= 16'h0000;
      txd_pin   <= 1'b1;
    end
    else if (adv)
    begin
      if (!ir_coding)
      begin
        pulse_cnt <= 16'h0000;
        txd_pin   <= txd_raw;                                  // see RULE16
      end
      else if (baud_tick && !txd_raw)
      begin
        pulse_cnt <= pulse_len - 16'h0001;                     // see RULE15
        txd_pin   <= 1'b0;
      end
      else if (pulse_cnt != 16'h0000)
        pulse_cnt <= pulse_cnt - 16'h0001;
      else
        txd_pin <= 1'b1;
    end
  end

  // receive source: event channel replaces the pin; a halted block ignores events
  assign rx_src = ir_event_input_enable ? (ir_event_in && run) : rxd_pin;          // see RULE13

  // glitch filter: the new level must repeat x+1 times before it is passed on
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      filt_cnt     <= 8'h00;
      rx_to_engine <= 1'b1;
    end
    else if (adv)
    begin
      if (!ir_coding || rx_pulse_length == 7'h00)
      begin
        filt_cnt     <= 8'h00;
        rx_to_engine <= rx_src;                                // see RULE19
      end
      else if (rx_src == rx_to_engine)
        filt_cnt <= 8'h00;
      else if (filt_cnt >= {1'b0, rx_pulse_length})
      begin
        filt_cnt     <= 8'h00;
        rx_to_engine <= rx_src;                                // see RULE19
      end
      else
        filt_cnt <= filt_cnt + 8'h01;
    end
  end

  // checks
  property p_apb_answer;
    @(posedge clk) disable iff (!rst_b)
    (ce && psel && penable && !pready && apb_state == AP_IDLE) |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb access not answered");

  property p_lin_mode;
    @(posedge clk) disable iff (!rst_b)
    (ce && wr && idx == REG_RXTX && pwdata[2:1] == 2'h3) |=> cfg.lin_constrained_autobaud;
  endproperty
  a_lin_mode: assert property (p_lin_mode) else $error("lin mode decode wrong");  // see RULE1

  property p_addr_filter;
    @(posedge clk) disable iff (!rst_b)
    (ce && rx_frame.valid && cfg.multiproc_address_filter && !rx_frame.addr_bit) |=> !rx_accept;
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("frame without address accepted");  // see RULE2

  property p_parity_flag;
    @(posedge clk) disable iff (!rst_b)
    (adv && rx_frame.valid && rx_frame.addr_bit && cfg.parity_select == PAR_ODD && frame_reg[2:0] == 3'h3
     && (~^rx_frame.data[7:0]) != rx_frame.parity_bit) |=> parity_error_flag;
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("parity mismatch not flagged");  // see RULE5

  property p_baud_reload;
    @(posedge clk) disable iff (!rst_b)
    (ce && wr && idx == REG_BAUDL) |=> (baud_cnt == 16'h0000 && baud_divisor[7:0] == $past(pwdata[7:0]));
  endproperty
  a_baud_reload: assert property (p_baud_reload) else $error("baud write did not reload");  // see RULE11

  property p_debug_halt;
    @(posedge clk) disable iff (!rst_b)
    (!run_in_debug_halt && cpu_halted && !wr) |=> $stable(baud_cnt);
  endproperty
  a_debug_halt: assert property (p_debug_halt) else $error("prescaler ran while halted");  // see RULE12

  property p_tx_bypass;
    @(posedge clk) disable iff (!rst_b)
    (adv && tx_pulse_length == 8'hff) |=> (txd_pin == $past(txd_raw));
  endproperty
  a_tx_bypass: assert property (p_tx_bypass) else $error("bypass altered transmit line");  // see RULE16

  property p_fixed_pulse;
    @(posedge clk) disable iff (!rst_b)
    (ce && run && ir_mode && tx_pulse_length == 8'h04 && baud_tick && !txd_raw && pulse_cnt == 16'h0000)
      ##1 (ce && run && !baud_tick)[*4] |-> !txd_pin ##1 txd_pin;
  endproperty
  a_fixed_pulse: assert property (p_fixed_pulse) else $error("fixed pulse length wrong");  // see RULE15

  property p_sync_char;
    @(posedge clk) disable iff (!rst_b)
    (adv && sync_meas.done && cfg.lin_constrained_autobaud && sync_meas.char_val != 8'h55) |=> (sync_fail && !sync_ok);
  endproperty
  a_sync_char: assert property (p_sync_char) else $error("bad sync character accepted");  // see RULE18

  property p_event_input;
    @(posedge clk) disable iff (!rst_b)
    (adv && ir_event_input_enable && run && (!ir_coding || rx_pulse_length == 7'h00)) |=> (rx_to_engine == $past(ir_event_in));
  endproperty
  a_event_input: assert property (p_event_input) else $error("event input not used");  // see RULE13

endmodule : ufb_config

// file: core/ufb_pkg.sv
// package for the serial frame, baud and infrared configuration block
// assumes a 32-bit apb master and word-aligned register slots (byte address = 4 * index)
package ufb_pkg;

  // register indexes; byte address is four times the index
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_RXTX   = 6'h06;
  localparam logic [5:0] REG_FRAME  = 6'h07;
  localparam logic [5:0] REG_BAUDL  = 6'h08;
  localparam logic [5:0] REG_BAUDH  = 6'h09;
  localparam logic [5:0] REG_DEBUG  = 6'h0b;
  localparam logic [5:0] REG_EVIN   = 6'h0c;
  localparam logic [5:0] REG_TX_PULSE_LENGTH   = 6'h0d;
  localparam logic [5:0] REG_RX_PULSE_LENGTH   = 6'h0e;

  // reset values
  localparam logic [7:0]  FRAME_RESET = 8'h03;
  localparam logic [7:0]  RXTX_RESET  = 8'h00;
  localparam logic [15:0] BAUD_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // field masks and positions
  localparam logic [7:0] FRAME_SPI_MASK = 8'hc6;  // mode, bit order, clock phase
  localparam logic [7:0] RX_PULSE_LENGTH_MASK      = 8'h7f;
  localparam logic [7:0] RXTX_MASK      = 8'hc7;  // receiver, transmitter, rx mode, filter
  localparam int         ST_PARITY_ERROR_FLAG        = 0;
  localparam int         ST_SYNC_FAIL   = 1;
  localparam int         ST_SYNC_OK     = 2;
  localparam int         ST_RUN         = 3;

  // infrared pulse coding
  localparam logic [7:0] TX_PULSE_LENGTH_FRACTION = 8'h00;  // 3/16 of a bit period
  localparam logic [7:0] TX_PULSE_LENGTH_BYPASS   = 8'hff;
  localparam logic [1:0] PULSE_NUM     = 2'h3;
  localparam int         PULSE_SHIFT   = 4;

  // lin sync character check
  localparam logic [7:0] SYNC_CHAR    = 8'h55;
  localparam logic [4:0] SYNC_PAIR    = 5'd16;
  localparam logic [4:0] SYNC_TOL     = 5'd3;
  localparam logic [4:0] SYNC_PAIR_LO = SYNC_PAIR - SYNC_TOL;
  localparam logic [4:0] SYNC_PAIR_HI = SYNC_PAIR + SYNC_TOL;

  typedef enum logic [1:0] {CM_ASYNC = 2'h0, CM_SYNC = 2'h1, CM_IR = 2'h2, CM_MASTER_SPI_MODE = 2'h3} ufb_comm_mode_select_e;
  typedef enum logic [1:0] {PAR_OFF = 2'h0, PAR_RSVD = 2'h1, PAR_EVEN = 2'h2, PAR_ODD = 2'h3} ufb_parity_e;
  typedef enum logic [1:0] {RXM_NORMAL = 2'h0, RXM_DOUBLE = 2'h1, RXM_GEN = 2'h2, RXM_LIN = 2'h3} ufb_rxmode_e;
  typedef enum logic [2:0] {CS_5 = 3'h0, CS_6 = 3'h1, CS_7 = 3'h2, CS_8 = 3'h3,
                            CS_R4 = 3'h4, CS_R5 = 3'h5, CS_9L = 3'h6, CS_9H = 3'h7} ufb_csize_e;

  // configuration handed to the shift engines
  typedef struct packed {
    ufb_comm_mode_select_e  comm_mode_select;
    ufb_parity_e parity_select;
    logic        stop_bit_select;
    ufb_csize_e  char_size;
    logic        spi_bit_order;
    logic        spi_clock_phase;
    ufb_rxmode_e rx_mode;
    logic        lin_constrained_autobaud;
    logic        multiproc_address_filter;
    logic        receiver_enable_bit;
    logic        transmitter_enable_bit;
  } ufb_cfg_s;

  // one received character from the receive engine
  typedef struct packed {
    logic       valid;
    logic [8:0] data;
    logic       parity_bit;
    logic       addr_bit;
  } ufb_rx_frame_s;

  // lin sync measurement from the receive engine
  typedef struct packed {
    logic       done;
    logic [7:0] char_val;
    logic [4:0] pair_min;
    logic [4:0] pair_max;
  } ufb_sync_s;

endpackage : ufb_pkg

// file: tb/tb_usart_frame_baud_ir_config.sv
// self-checking bench for the frame, baud and infrared configuration block
// assumes the package and block under core/ and the node model under tb/
`timescale 1ns/1ns
module tb_usart_frame_baud_ir_config;
  import ufb_pkg::*;
  logic          clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, cpu_halted, baud_tick;
  logic          engine_run, tx_parity_bit, rx_accept, sync_ok, sync_fail, rxd_pin, ir_event_in;
  logic          txd_raw, txd_pin, rx_to_engine, lvl, se;
  logic [7:0]    paddr, w;
  logic [8:0]    tx_data;
  logic [31:0]   pwdata, prdata, q, seed;
  logic [5:0]    rix [7] = '{REG_FRAME, REG_BAUDL, REG_BAUDH, REG_DEBUG, REG_EVIN, REG_TX_PULSE_LENGTH, REG_RX_PULSE_LENGTH};
  ufb_cfg_s      cfg;
  ufb_rx_frame_s rx_frame;
  ufb_sync_s     sync_meas;
  int            fails, cmp_count, n;

  ufb_config DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_halted(cpu_halted), .cfg(cfg), .baud_tick(baud_tick), .engine_run(engine_run),
    .tx_data(tx_data), .tx_parity_bit(tx_parity_bit), .rx_frame(rx_frame), .rx_accept(rx_accept),
    .sync_meas(sync_meas), .sync_ok(sync_ok), .sync_fail(sync_fail), .rxd_pin(rxd_pin),
    .ir_event_in(ir_event_in), .txd_raw(txd_raw), .txd_pin(txd_pin), .rx_to_engine(rx_to_engine));
  ufb_node node (.clk(clk), .rst_b(rst_b), .lvl(lvl), .rxd_pin(rxd_pin));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // expected parity of an 8-bit character
  function automatic logic par(input logic [1:0] p, input logic [8:0] d);
    return p[1] ? ((^d[7:0]) ^ p[0]) : 1'b0;
  endfunction : par

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %0s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; waits for pready under a bound
  task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      end_sim();
    end
  endtask : bus

  task automatic rc(input logic [5:0] ix, input logic [31:0] e);
    bus(1'b0, ix, 32'h0);
    chk("register", e, q);
  endtask : rc

  // one received frame, then the accept pulse
  task automatic rxe(input logic a, input logic e);
    @(posedge clk);
    rx_frame <= '{1'b1, 9'h0a5, 1'b0, a};
    @(posedge clk);
    rx_frame.valid <= 1'b0;
    @(negedge clk);
    chk("rx_accept", e, rx_accept);
  endtask : rxe

  // one sync measurement, pair minimum fixed at the low edge of the window
  task automatic syn(input logic [7:0] c, input logic [4:0] hi, input logic ok);
    @(posedge clk);
    sync_meas <= '{1'b1, c, 5'd13, hi};
    @(posedge clk);
    sync_meas.done <= 1'b0;
    @(negedge clk);
    chk("sync_ok", ok, sync_ok);
    chk("sync_fail", !ok, sync_fail);
  endtask : syn

  // count cycles between two bit ticks, or the length of one low pulse
  task automatic cnt(input logic lo);
    n = 0;
    while ((lo ? txd_pin !== 1'b0 : baud_tick !== 1'b1) && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    n = (n >= 600) ? 600 : 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((lo ? txd_pin === 1'b0 : baud_tick !== 1'b1) && n < 600);
    if (n >= 600)
    begin
      fails++;
      end_sim();
    end
  endtask : cnt

  initial
  begin
    {rst_b, psel, penable, pwrite, cpu_halted, ir_event_in, paddr, pwdata, tx_data} = '0;
    {rx_frame, sync_meas} = '0;
    {txd_raw, lvl, ce} = 3'b111;
    {seed, fails, cmp_count} = {32'h5, 32'h0, 32'h0};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rix[i]) rc(rix[i], (i == 0) ? 32'h3 : 32'h0);
    bus(1'b1, 6'h01, 32'hff);
    bus(1'b0, 6'h01, 32'h0);
    chk("slverr", 32'h1, se);
    for (int i = 0; i < 6; i++)
    begin
      q = xs();
      w = {1'b0, q[6:0]};
      bus(1'b1, REG_FRAME, w);
      rc(REG_FRAME, w);
      chk("parity_select", w[5:4], cfg.parity_select);
      chk("stop_bit_select", w[3], cfg.stop_bit_select);
      chk("char_size", w[2:0], cfg.char_size);
    end
    bus(1'b1, REG_FRAME, 32'hff);
    rc(REG_FRAME, 32'hc6);
    chk("comm_mode", CM_MASTER_SPI_MODE, cfg.comm_mode_select);
    bus(1'b1, REG_RX_PULSE_LENGTH, 32'hff);
    rc(REG_RX_PULSE_LENGTH, 32'h7f);
    $display("test registers done");
    for (int p = 0; p < 4; p++)
    begin
      bus(1'b1, REG_FRAME, {26'h0, p[1:0], 4'h3});
      q = xs();
      tx_data <= q[8:0];
      @(posedge clk);
      @(negedge clk);
      chk("tx_parity_bit", par(p[1:0], tx_data), tx_parity_bit);
    end
    bus(1'b1, REG_RXTX, 32'h01);
    rxe(1'b0, 1'b0);
    rxe(1'b1, 1'b1);
    bus(1'b1, REG_RXTX, 32'h06);
    syn(8'h55, 5'd19, 1'b1);
    syn(8'h55, 5'd20, 1'b0);
    syn(8'h54, 5'd16, 1'b0);
    rc(REG_STATUS, 32'h0f);
    bus(1'b1, REG_STATUS, 32'h07);
    rc(REG_STATUS, 32'h08);
    $display("test engine done");
    bus(1'b1, REG_BAUDL, 32'h03);
    bus(1'b1, REG_BAUDH, 32'h00);
    cnt(1'b0);
    chk("baud period", 32'd4, n);
    bus(1'b1, REG_BAUDH, 32'h01);
    cnt(1'b0);
    chk("baud period", 32'd260, n);
    bus(1'b1, REG_TX_PULSE_LENGTH, 32'h04);
    bus(1'b1, REG_FRAME, 32'h83);
    bus(1'b1, REG_RXTX, 32'h40);
    txd_raw <= 1'b0;
    cnt(1'b1);
    chk("pulse length", 32'd4, n);
    bus(1'b1, REG_TX_PULSE_LENGTH, 32'hff);
    lvl <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("txd_pin", 32'h0, txd_pin);
    chk("rx_to_engine", 32'h0, rx_to_engine);
    bus(1'b1, REG_EVIN, 32'h01);
    lvl <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("rx_to_engine", 32'h0, rx_to_engine);
    ir_event_in <= 1'b1;
    lvl <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("rx_to_engine", 32'h1, rx_to_engine);
    $display("test baud and infrared done");
    @(posedge clk);
    cpu_halted <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("engine_run", 32'h0, engine_run);
    bus(1'b1, REG_DEBUG, 32'h01);
    @(posedge clk);
    @(negedge clk);
    chk("engine_run", 32'h1, engine_run);
    $display("test debug done");
    end_sim();
  end
endmodule : tb_usart_frame_baud_ir_config

// file: tb/ufb_node.sv
// remote serial node model: drives the receive line toward the block
// assumes the bench hands it one line level per clock, registered here
`timescale 1ns/1ns
module ufb_node (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // asked level and the serial line
  input  wire logic lvl,
  output logic      rxd_pin
);
  // line idles high out of reset, as an idle serial line does
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rxd_pin <= 1'b1;
    else
      rxd_pin <= lvl;
  end
endmodule : ufb_node
